// ==== rtl/tbs_pkg.sv ====
// constants and types shared by the touch burst sequencer
package tbs_pkg;

  // ********************************
  // clock and timing
  // ********************************
  localparam int unsigned TBS_CLK_HZ = 25_000_000;
  localparam int unsigned TBS_FAST_GAP_US = 1000;
  localparam int unsigned TBS_FAST_GAP_CYC = TBS_FAST_GAP_US * (TBS_CLK_HZ / 1_000_000);
  localparam int unsigned TBS_SLEEP_MS = 85;
  localparam int unsigned TBS_SLEEP_CYC = TBS_SLEEP_MS * (TBS_CLK_HZ / 1000);
  localparam int unsigned TBS_HB_US = 15;
  localparam int unsigned TBS_HB_CYC = (TBS_HB_US * TBS_CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned TBS_PACE_MIN_US = 10;
  localparam int unsigned TBS_PACE_MIN_CYC = (TBS_PACE_MIN_US * TBS_CLK_HZ + 999_999) / 1_000_000;

  // ********************************
  // signal processing
  // ********************************
  localparam int unsigned TBS_SAMPLE_W = 16;
  localparam logic [15:0] TBS_THRESH = 16'h000A;
  localparam logic [15:0] TBS_HYST = 16'h0002;
  localparam logic [2:0] TBS_INTEG_LIMIT = 3'h4;
  localparam int unsigned TBS_MAX_ON_MEAS = 3809;
  localparam int unsigned TBS_DRIFT_UP_MEAS = 16;
  localparam int unsigned TBS_DRIFT_DN_MEAS = 4;
  localparam int unsigned TBS_SPREAD_MAX = 75;

  // ********************************
  // reset values
  // ********************************
  localparam logic [31:0] TBS_CNT_RST = 32'h0000_0000;
  localparam logic [2:0] TBS_INTEG_RST = 3'h0;

  // ********************************
  // modes and states
  // ********************************
  typedef enum logic [2:0] {
    TBS_MD_FAST = 3'b001,
    TBS_MD_SLOW = 3'b010,
    TBS_MD_PACED = 3'b100
  } tbs_mode_t;

  typedef enum logic [2:0] {
    TBS_ST_GAP = 3'b001,
    TBS_ST_BEAT = 3'b010,
    TBS_ST_BURST = 3'b100
  } tbs_state_t;

endpackage : tbs_pkg

// ==== rtl/tbs_spread.sv ====
// triangle sweep of the oscillator trim during a burst
`timescale 1ns/10ps
module tbs_spread #(
  parameter int unsigned MAX_DEV = tbs_pkg::TBS_SPREAD_MAX
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  output logic signed [7:0] trim_out
);
  import tbs_pkg::*;

  // ********************************
  // sweep
  // ********************************
  localparam logic signed [7:0] LIM = 8'(MAX_DEV);
  logic up;
  wire at_top = trim_out >= LIM;
  wire at_bot = trim_out <= -LIM;
  wire next_up = at_top ? 1'b0 : (at_bot ? 1'b1 : up);
  wire signed [7:0] next_trim = !run_in ? 8'sh00 : (next_up ? trim_out + 8'sh01 : trim_out - 8'sh01);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      up <= 1'b1;
      trim_out <= 8'sh00;
    end else begin
      up <= run_in ? next_up : 1'b1;
      trim_out <= next_trim;
    end
  end

  // ********************************
  // checks
  // ********************************
  AST_SPREAD_BOUND: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (trim_out <= LIM) && (trim_out >= -LIM))
    else $error("oscillator trim outside spread range");
  AST_SPREAD_IDLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !$past(run_in) |-> trim_out == 8'sh00)
    else $error("oscillator trim not centred outside burst");

endmodule : tbs_spread

// ==== rtl/tbs_touch_seq.sv ====
// burst scheduling, detection filtering and output control of a one-key touch sensor
// Behaviour
// - pace high: full speed, about 1 ms between bursts
// - pace low in slow scan: sleep about 85 ms after each burst
// - slow scan: possible touch uses full-speed gaps until integrator resolves it
// - pace sampled at burst end; low in full speed enters paced mode
// - paced mode: each pace change, rising or falling, wakes one burst
// - paced short pulses over 10 us: burst only on leading edge
// - pace unchanged beyond sleep period leaves paced mode by pace level
// - paced mode: integrator bypassed, single above-threshold measurement detects
// - recalibration timeout counts measurements, not time
// - fixed threshold: signal ten counts above reference
// - detection held down to two counts below threshold, released below that
// - detection lasting past maximum on-duration forces full recalibration
// - on-duration timer advances once per burst
// - integrator counts to four; any miss clears it at once
// - no recalibration input; only power-up or timeout recalibrates
// - reference tracks signal in limited steps only without detection
// - reference follows falling signal faster than rising signal
// - oscillator swept plus or minus 7.5 percent during each burst
// - output high during detection; low after on-duration timeout
// - slow and paced modes: output released 15 us before each burst
// - timing counts independent of supply, 2.0 V to 5.5 V
`timescale 1ns/10ps
module tbs_touch_seq #(
  parameter int unsigned FAST_GAP_CYC = tbs_pkg::TBS_FAST_GAP_CYC,
  parameter int unsigned SLEEP_CYC = tbs_pkg::TBS_SLEEP_CYC,
  parameter int unsigned MAX_ON_MEAS = tbs_pkg::TBS_MAX_ON_MEAS,
  parameter int unsigned DRIFT_UP_MEAS = tbs_pkg::TBS_DRIFT_UP_MEAS,
  parameter int unsigned DRIFT_DN_MEAS = tbs_pkg::TBS_DRIFT_DN_MEAS,
  parameter int unsigned SAMPLE_W = tbs_pkg::TBS_SAMPLE_W
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PACE_IN,
  input wire logic [SAMPLE_W-1:0] SAMPLE_IN,
  input wire logic SAMPLE_VALID_IN,
  output logic BURST_START_OUT,
  output logic BURST_ACTIVE_OUT,
  output logic DETECT_OUT,
  output logic DETECT_OE_N_OUT,
  output tbs_pkg::tbs_mode_t MODE_OUT,
  output logic signed [7:0] SPREAD_OUT
);
  import tbs_pkg::*;

  // ********************************
  // helpers
  // ********************************
  function automatic logic is_above(input logic [SAMPLE_W-1:0] s, input logic [SAMPLE_W-1:0] r,
                                    input logic [15:0] lvl);
    logic [SAMPLE_W:0] d;
    d = {1'b0, s} - {1'b0, r};
    is_above = (s > r) && (d >= (SAMPLE_W+1)'(lvl));
  endfunction : is_above

  function automatic logic [31:0] inc32(input logic [31:0] v);
    inc32 = v + 32'h0000_0001;
  endfunction : inc32

  // ********************************
  // state
  // ********************************
  tbs_state_t state;
  tbs_state_t next_state;
  tbs_mode_t mode;
  tbs_mode_t next_mode;
  logic [31:0] gap_cnt;
  logic [31:0] idle_cnt;
  logic [31:0] on_cnt;
  logic [31:0] hold_cnt;
  logic [31:0] hb_cnt;
  logic [31:0] drift_cnt;
  logic pace_lvl;
  logic pace_evt;
  logic [2:0] integ;
  logic [SAMPLE_W-1:0] base_ref;
  logic detect;
  logic recal_pend;

  // ********************************
  // decode
  // ********************************
  wire sample_fire = (state == TBS_ST_BURST) && SAMPLE_VALID_IN;
  wire above = is_above(SAMPLE_IN, base_ref, TBS_THRESH);
  wire still_on = is_above(SAMPLE_IN, base_ref, TBS_THRESH - TBS_HYST);
  wire resolving = integ != TBS_INTEG_RST;
  wire [31:0] gap_target = ((mode == TBS_MD_SLOW) && !resolving) ? 32'(SLEEP_CYC) : 32'(FAST_GAP_CYC);
  wire gap_done = (state == TBS_ST_GAP) && (mode != TBS_MD_PACED) && (gap_cnt >= gap_target - 32'h1);
  wire pace_timeout = (mode == TBS_MD_PACED) && (idle_cnt >= 32'(SLEEP_CYC));
  wire paced_trig = (state == TBS_ST_GAP) && (mode == TBS_MD_PACED) && pace_evt && !pace_timeout;
  wire hb_done = (state == TBS_ST_BEAT) && (hb_cnt >= 32'(TBS_HB_CYC) - 32'h1);
  wire max_on_hit = sample_fire && detect && (on_cnt >= 32'(MAX_ON_MEAS) - 32'h1);
  wire recal_now = sample_fire && (recal_pend || max_on_hit);
  wire judge = sample_fire && !recal_now;
  wire confirm = judge && !detect && above && ((mode == TBS_MD_PACED) || (integ == TBS_INTEG_LIMIT - 3'h1));
  wire release_now = judge && detect && !still_on;
  wire drift_ok = judge && !detect && !above;
  wire drift_dn = SAMPLE_IN < base_ref;
  wire drift_up = SAMPLE_IN > base_ref;
  wire [31:0] drift_lim = drift_dn ? 32'(DRIFT_DN_MEAS) : 32'(DRIFT_UP_MEAS);
  wire drift_step = drift_ok && (drift_up || drift_dn) && (drift_cnt >= drift_lim - 32'h1);
  wire start_burst = (gap_done && (mode == TBS_MD_FAST)) || hb_done;
  wire start_beat = (gap_done && (mode != TBS_MD_FAST)) || paced_trig;
  wire pace_accept = (PACE_IN != pace_lvl) && (hold_cnt >= 32'(TBS_PACE_MIN_CYC) - 32'h1);

  // ********************************
  // sequencer
  // ********************************
  always_comb begin
    next_state = state;
    case (state)
      TBS_ST_GAP: begin
        if (start_burst) begin
          next_state = TBS_ST_BURST;
        end else if (start_beat) begin
          next_state = TBS_ST_BEAT;
        end
      end
      TBS_ST_BEAT: begin
        if (hb_done) begin
          next_state = TBS_ST_BURST;
        end
      end
      TBS_ST_BURST: begin
        if (SAMPLE_VALID_IN) begin
          next_state = TBS_ST_GAP;
        end
      end
      default: begin
        next_state = TBS_ST_GAP;
      end
    endcase
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      TBS_MD_FAST: begin
        if (sample_fire && !pace_lvl) begin
          next_mode = TBS_MD_PACED;
        end
      end
      TBS_MD_SLOW: begin
        if (sample_fire && pace_lvl) begin
          next_mode = TBS_MD_FAST;
        end
      end
      TBS_MD_PACED: begin
        if ((state == TBS_ST_GAP) && pace_timeout) begin
          next_mode = pace_lvl ? TBS_MD_FAST : TBS_MD_SLOW;
        end
      end
      default: begin
        next_mode = TBS_MD_FAST;
      end
    endcase
  end

  wire [31:0] next_gap = ((state == TBS_ST_GAP) && (next_state == TBS_ST_GAP) && (next_mode == mode)) ?
                         inc32(gap_cnt) : TBS_CNT_RST;
  wire [31:0] next_idle = ((mode != TBS_MD_PACED) || pace_evt) ? TBS_CNT_RST : inc32(idle_cnt);
  wire [31:0] next_hold = ((PACE_IN == pace_lvl) || pace_accept) ? TBS_CNT_RST : inc32(hold_cnt);

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state <= TBS_ST_GAP;
      mode <= TBS_MD_FAST;
      gap_cnt <= TBS_CNT_RST;
      idle_cnt <= TBS_CNT_RST;
      hb_cnt <= TBS_CNT_RST;
    end else begin
      state <= next_state;
      mode <= next_mode;
      gap_cnt <= next_gap;
      idle_cnt <= next_idle;
      hb_cnt <= (state == TBS_ST_BEAT) ? inc32(hb_cnt) : TBS_CNT_RST;
    end
  end

  // ********************************
  // pace pin filter
  // ********************************
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pace_lvl <= 1'b0;
      pace_evt <= 1'b0;
      hold_cnt <= TBS_CNT_RST;
    end else begin
      hold_cnt <= next_hold;
      pace_evt <= pace_accept;
      if (pace_accept) begin
        pace_lvl <= PACE_IN;
      end
    end
  end

  // ********************************
  // detection and reference
  // ********************************
  wire [2:0] next_integ = (recal_now || confirm || !judge && sample_fire) ? TBS_INTEG_RST :
                          (!judge || detect) ? integ : (above ? integ + 3'h1 : TBS_INTEG_RST);
  wire next_detect = recal_now ? 1'b0 : (confirm ? 1'b1 : (release_now ? 1'b0 : detect));
  wire [31:0] next_on = (recal_now || release_now || !detect) ? TBS_CNT_RST :
                        (sample_fire ? inc32(on_cnt) : on_cnt);
  wire [SAMPLE_W-1:0] next_ref = recal_now ? SAMPLE_IN :
                                 (!drift_step ? base_ref :
                                 (drift_dn ? base_ref - SAMPLE_W'(1) : base_ref + SAMPLE_W'(1)));
  wire [31:0] next_drift = (recal_now || (judge && !drift_ok) || drift_step || (drift_ok && !drift_up && !drift_dn)) ?
                           TBS_CNT_RST : (drift_ok ? inc32(drift_cnt) : drift_cnt);

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      integ <= TBS_INTEG_RST;
      detect <= 1'b0;
      on_cnt <= TBS_CNT_RST;
      drift_cnt <= TBS_CNT_RST;
      base_ref <= '0;
      recal_pend <= 1'b1;
    end else begin
      integ <= next_integ;
      detect <= next_detect;
      on_cnt <= next_on;
      drift_cnt <= next_drift;
      base_ref <= next_ref;
      recal_pend <= recal_pend && !sample_fire;
    end
  end

  // ********************************
  // outputs
  // ********************************
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      BURST_START_OUT <= 1'b0;
      BURST_ACTIVE_OUT <= 1'b0;
      DETECT_OE_N_OUT <= 1'b0;
    end else begin
      BURST_START_OUT <= (state != TBS_ST_BURST) && (next_state == TBS_ST_BURST);
      BURST_ACTIVE_OUT <= next_state == TBS_ST_BURST;
      DETECT_OE_N_OUT <= next_state == TBS_ST_BEAT;
    end
  end

  assign DETECT_OUT = detect;
  assign MODE_OUT = mode;

  tbs_spread #(
    .MAX_DEV(TBS_SPREAD_MAX)
  ) u_spread (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .run_in(state == TBS_ST_BURST),
    .trim_out(SPREAD_OUT)
  );

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  logic detect_q;
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      detect_q <= 1'b0;
    end else begin
      detect_q <= detect;
    end
  end

  AST_FAST_GAP: assert property (BURST_START_OUT && $past(mode) == TBS_MD_FAST && mode == TBS_MD_FAST
    |-> $past(gap_cnt) == 32'(FAST_GAP_CYC) - 32'h1)
    else $error("full-speed gap length wrong");
  AST_HB_BEFORE_BURST: assert property ($rose(BURST_START_OUT) && mode != TBS_MD_FAST
    |-> $past(DETECT_OE_N_OUT))
    else $error("burst started without release pulse");
  AST_HB_WIDTH: assert property ($fell(DETECT_OE_N_OUT) |-> hb_cnt == 32'(TBS_HB_CYC))
    else $error("release pulse width wrong");
  AST_INTEG_FOUR: assert property ($rose(detect) && $past(mode) != TBS_MD_PACED
    |-> $past(integ) == TBS_INTEG_LIMIT - 3'h1)
    else $error("detection before four confirmations");
  AST_PACED_SINGLE: assert property (judge && mode == TBS_MD_PACED && !detect && above |=> detect)
    else $error("paced measurement above threshold not detected");
  AST_REF_FROZEN: assert property (detect && detect_q |-> $stable(base_ref))
    else $error("reference moved during detection");
  AST_PACED_ENTRY: assert property (sample_fire && mode == TBS_MD_FAST && !pace_lvl
    |=> mode == TBS_MD_PACED)
    else $error("low pace at burst end did not enter paced mode");
  AST_PACE_WAKE: assert property (paced_trig |=> state == TBS_ST_BEAT ##1 DETECT_OE_N_OUT)
    else $error("pace change did not wake a burst");
  AST_MAX_ON: assert property (max_on_hit |=> !DETECT_OUT && base_ref == $past(SAMPLE_IN))
    else $error("on-duration expiry did not recalibrate");
  AST_SHORT_PULSE: assert property ($rose(DETECT_OE_N_OUT) && mode == TBS_MD_PACED
    |-> $past(pace_evt) && $past(state) == TBS_ST_GAP)
    else $error("pace edge during burst started another burst");

  COV_PACED: cover property (sample_fire && mode == TBS_MD_FAST && !pace_lvl);
  COV_CONFIRM: cover property ($rose(detect) && mode == TBS_MD_SLOW);
  COV_TIMEOUT: cover property (max_on_hit);
  COV_LEAVE_PACED: cover property (mode == TBS_MD_PACED && next_mode == TBS_MD_SLOW);

endmodule : tbs_touch_seq

// ==== dv/tbs_front_model.sv ====
// analog front-end model answering each measurement burst
`timescale 1ns/10ps
module tbs_front_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic burst_in,
  input wire logic [7:0] delay_in,
  input wire logic [15:0] level_in,
  output logic valid_out,
  output logic [15:0] sample_out
);
  logic [7:0] cnt;
  logic done;

  // ********************************
  // one sample per burst, after delay_in cycles
  // ********************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 8'h00;
      done <= 1'b0;
      valid_out <= 1'b0;
      sample_out <= 16'h0000;
    end else begin
      valid_out <= 1'b0;
      if (!burst_in) begin
        cnt <= 8'h00;
        done <= 1'b0;
        sample_out <= ~sample_out;
      end else if (!done && cnt == delay_in) begin
        valid_out <= 1'b1;
        sample_out <= level_in;
        done <= 1'b1;
      end else if (!done) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule : tbs_front_model

// ==== dv/tbs_touch_seq_bench.sv ====
// self-checking bench of the touch burst sequencer
`timescale 1ns/10ps
module tbs_touch_seq_bench;
  import tbs_pkg::*;
  typedef struct {logic [15:0] v; logic d;} tbs_row_t;
  localparam int FG = 300;
  localparam int SL = 2000;
  localparam int MO = 6;
  logic clk, rstn, pace, vld, bs, ba, det, oen, hb;
  logic [15:0] lvl, smp;
  logic [7:0] dly;
  logic signed [7:0] spr, mx, mn;
  tbs_mode_t md;
  int failures, check_count, cyc, g, n;
  tbs_row_t rows [10] = '{'{16'h0064, 1'b0}, '{16'h006E, 1'b0}, '{16'h006E, 1'b0}, '{16'h0069, 1'b0},
    '{16'h006E, 1'b0}, '{16'h006E, 1'b0}, '{16'h006E, 1'b0}, '{16'h006E, 1'b1}, '{16'h006C, 1'b1},
    '{16'h006B, 1'b0}};

  tbs_touch_seq #(.FAST_GAP_CYC(FG), .SLEEP_CYC(SL), .MAX_ON_MEAS(MO)) i_dut (.CLK_IN(clk), .RSTN_IN(rstn),
    .PACE_IN(pace), .SAMPLE_IN(smp), .SAMPLE_VALID_IN(vld), .BURST_START_OUT(bs), .BURST_ACTIVE_OUT(ba),
    .DETECT_OUT(det), .DETECT_OE_N_OUT(oen), .MODE_OUT(md), .SPREAD_OUT(spr));
  tbs_front_model i_fe (.clk_in(clk), .rstn_in(rstn), .burst_in(ba), .delay_in(dly), .level_in(lvl),
    .valid_out(vld), .sample_out(smp));

  // ********************************
  // clock, watchdog and helpers
  // ********************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 45000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic meas(input logic [15:0] v);
    lvl = v;
    g = 0;
    hb = 1'b0;
    mx = 8'sh00;
    mn = 8'sh00;
    while (bs !== 1'b1 && g < 3 * SL) begin
      tick(1);
      g++;
      if (oen === 1'b1) hb = 1'b1;
    end
    for (int k = 0; k < 300 && ba === 1'b1; k++) begin
      tick(1);
      if (spr > mx) mx = spr;
      if (spr < mn) mn = spr;
    end
  endtask : meas

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ********************************
  // main sequence
  // ********************************
  initial begin
    rstn = 1'b0;
    pace = 1'b1;
    lvl = 16'h0064;
    dly = 8'h50;
    tick(6);
    chk({bs, ba, det, oen, md, spr}, {4'h0, TBS_MD_FAST, 8'h00});
    rstn = 1'b1;
    foreach (rows[i]) begin
      meas(rows[i].v);
      chk(det, rows[i].d);
      chk(g >= FG - 1 && g <= FG + 3, 1'b1);
      chk({hb, md}, {1'b0, TBS_MD_FAST});
      tick(1);
      chk(mx <= 75 && mn >= -75 && mx != mn && spr === 8'sh00, 1'b1);
    end
    dly = 8'h02;
    for (int k = 0; k < 4; k++) meas(16'h0078);
    chk(det, 1'b1);
    n = 0;
    while (det === 1'b1 && n < MO + 2) begin
      meas(16'h0078);
      n++;
    end
    chk(n >= MO - 1 && n <= MO + 1, 1'b1);
    meas(16'h0078);
    chk(det, 1'b0);
    for (int k = 0; k < 4; k++) begin
      meas(16'h0082);
      chk(det, k == 3);
    end
    meas(16'h0080);
    chk(det, 1'b1);
    meas(16'h007F);
    chk(det, 1'b0);
    pace = 1'b0;
    n = 0;
    while (md !== TBS_MD_PACED && n < 40) begin
      meas(16'h007F);
      n++;
    end
    chk(md, TBS_MD_PACED);
    pace = 1'b1;
    fork
      begin
        tick(300);
        pace = 1'b0;
      end
      meas(16'h008C);
    join
    chk(g > 375 && g < 700 && hb, 1'b1);
    chk(det, 1'b1);
    n = 0;
    repeat (700) begin
      tick(1);
      if (bs === 1'b1) n++;
    end
    chk(n, 0);
    for (int k = 0; k < 4; k++) begin
      pace = ~pace;
      meas(16'h007F);
      chk({g > 375 && g < 700, det, md}, {2'b10, TBS_MD_PACED});
    end
    meas(16'h007F);
    chk(md, TBS_MD_SLOW);
    meas(16'h007F);
    chk(g >= SL && g <= SL + 400 && hb, 1'b1);
    for (int k = 0; k < 4; k++) begin
      meas(16'h008C);
      chk(det, k == 3);
      if (k > 0) chk(g < SL, 1'b1);
    end
    meas(16'h007F);
    chk(det, 1'b0);
    meas(16'h007F);
    chk(g >= SL && md === TBS_MD_SLOW, 1'b1);
    pace = 1'b1;
    meas(16'h007F);
    chk(md, TBS_MD_FAST);
    tick(5);
    rstn = 1'b0;
    tick(2);
    chk({bs, ba, det, oen, md, spr}, {4'h0, TBS_MD_FAST, 8'h00});
    rstn = 1'b1;
    meas(16'h0090);
    chk(det, 1'b0);
    end_of_test();
  end
endmodule : tbs_touch_seq_bench
